// ---- core/brs_end_match.sv ----
`timescale 1ns/1ps
module brs_end_match
   import brs_pkg::*;
(
   brs_match_if.cmp m
);

   brs_word_t win_first;
   logic      at_end;

   // Word compare: second word of a two-word last instruction never matches
   assign win_first  = brs_word_t'(m.end_addr - (BRS_DEFER_WORDS - 16'h0001));
   assign at_end     = m.active & brs_addr_eq(m.pc, m.end_addr);
   assign m.match_loop = at_end & ~m.count_zero;
   assign m.match_exit = at_end & m.count_zero;
   assign m.in_window  = m.active & (brs_addr_eq(m.pc, m.end_addr)
                                     | brs_addr_eq(m.pc, win_first));

endmodule

// ---- core/brs_match_if.sv ----
`timescale 1ns/1ps
interface brs_match_if;
   import brs_pkg::*;

   brs_word_t pc;
   brs_word_t end_addr;
   logic      active;
   logic      count_zero;
   logic      match_loop;
   logic      match_exit;
   logic      in_window;

   modport seq (output pc, end_addr, active, count_zero,
                input  match_loop, match_exit, in_window);
   modport cmp (input  pc, end_addr, active, count_zero,
                output match_loop, match_exit, in_window);
endinterface

// ---- core/brs_pkg.sv ----
package brs_pkg;

   localparam int BRS_AW = 16;
   localparam int BRS_RW = 2;

   typedef logic [BRS_AW-1:0] brs_word_t;
   typedef logic [BRS_RW-1:0] brs_reg_t;

   // Register offsets on the register port
   localparam brs_reg_t BRS_OFF_LOOP_COUNT = 2'h0;
   localparam brs_reg_t BRS_OFF_START_ADDR = 2'h1;
   localparam brs_reg_t BRS_OFF_END_ADDR   = 2'h2;
   localparam brs_reg_t BRS_OFF_MODE       = 2'h3;

   // Field position of the active flag in the mode status register
   localparam int BRS_ACTIVE_BIT = 0;

   // Values after reset
   localparam brs_word_t BRS_RST_LOOP_COUNT = 16'h0000;
   localparam brs_word_t BRS_RST_START_ADDR = 16'h0000;
   localparam brs_word_t BRS_RST_END_ADDR   = 16'h0000;
   localparam brs_word_t BRS_RST_MODE       = 16'h0000;
   localparam brs_word_t BRS_RD_IDLE        = 16'h0000;

   // Words at the block end during which interrupts are held off
   localparam brs_word_t BRS_DEFER_WORDS = 16'h0002;

   // Word-address equality, used for both the end match and the window
   function automatic logic brs_addr_eq(input brs_word_t a, input brs_word_t b);
      return a == b;
   endfunction

endpackage

// ---- core/brs_sequencer.sv ----
// How it works
// - Loop counter holds 0 to 65,535
// - Repeat-block loads start and end addresses
// - Repeat-block sets the active flag
// - End match, nonzero count: decrement, jump start
// - End match, zero count: clear flag, continue
// - One register set; software saves nested context
// - Active flag is mode bit 0, writable
// - Software clear finishes pass, then falls through
// - Count, start, end registers readable and writable
// - Branches, calls, interrupts keep loop state
// - Loop-back at fetch; call pushes start
// - Word compare; two-word tail gets start
// - Interrupts held during last two words
// - Held interrupt taken at start or past
// - Interrupts outside window taken, loop resumes
// - Single repeats inside block leave state alone
// - Reset clears the active flag
`timescale 1ns/1ps
module brs_sequencer
   import brs_pkg::*;
(
   input  wire logic      i_sys_clk,
   input  wire logic      i_sys_rst,
   input  wire brs_reg_t  i_reg_addr,
   input  wire brs_word_t i_reg_wdata,
   input  wire logic      i_reg_wr,
   input  wire logic      i_reg_rd,
   output logic [15:0]    o_reg_rdata,
   input  wire logic      i_pc_upd,
   input  wire brs_word_t i_pc,
   input  wire logic      i_repeat_block_instr_exec,
   input  wire brs_word_t i_repeat_block_instr_next_addr,
   input  wire brs_word_t i_repeat_block_instr_end_addr,
   output logic           o_redirect,
   output logic [15:0]    o_redirect_addr,
   output logic           o_loop_exit,
   output logic           o_int_defer,
   output logic           o_block_repeat_active
);

   brs_word_t block_loop_count_r;
   brs_word_t block_loop_count_nxt;
   brs_word_t block_start_addr_r;
   brs_word_t block_start_addr_nxt;
   brs_word_t block_end_addr_r;
   brs_word_t block_end_addr_nxt;
   brs_word_t proc_mode_status_r;
   brs_word_t proc_mode_status_nxt;
   brs_word_t rdata_r;
   brs_word_t rdata_nxt;
   brs_word_t redirect_addr_r;
   brs_word_t redirect_addr_nxt;
   logic      redirect_r;
   logic      redirect_nxt;
   logic      loop_exit_r;
   logic      loop_exit_nxt;
   logic      int_defer_r;
   logic      int_defer_nxt;
   logic      active;
   logic      wr_count;
   logic      wr_start;
   logic      wr_end;
   logic      wr_mode;
   logic      do_loop;
   logic      do_exit;
   logic      in_window;

   brs_match_if u_mif ();

   assign active           = proc_mode_status_r[BRS_ACTIVE_BIT];
   assign u_mif.pc         = i_pc;
   assign u_mif.end_addr   = block_end_addr_r;
   assign u_mif.active     = active;
   assign u_mif.count_zero = (block_loop_count_r == BRS_RST_LOOP_COUNT);

   brs_end_match u_match (
      .m (u_mif)
   );

   // Decisions only on a fetch-address update
   assign do_loop   = i_pc_upd & u_mif.match_loop;
   assign do_exit   = i_pc_upd & u_mif.match_exit;
   assign in_window = u_mif.in_window;

   assign wr_count = i_reg_wr & (i_reg_addr == BRS_OFF_LOOP_COUNT);
   assign wr_start = i_reg_wr & (i_reg_addr == BRS_OFF_START_ADDR);
   assign wr_end   = i_reg_wr & (i_reg_addr == BRS_OFF_END_ADDR);
   assign wr_mode  = i_reg_wr & (i_reg_addr == BRS_OFF_MODE);

   // Loop registers
   always_comb begin
      block_loop_count_nxt = block_loop_count_r;
      block_start_addr_nxt = block_start_addr_r;
      block_end_addr_nxt   = block_end_addr_r;
      proc_mode_status_nxt = proc_mode_status_r;
      // Software restore of the count wins over a same-cycle decrement
      if (wr_count) begin
         block_loop_count_nxt = i_reg_wdata;
      end else if (do_loop) begin
         block_loop_count_nxt = brs_word_t'(block_loop_count_r - 16'h0001);
      end
      if (i_repeat_block_instr_exec) begin
         block_start_addr_nxt = i_repeat_block_instr_next_addr;
         block_end_addr_nxt   = i_repeat_block_instr_end_addr;
      end else begin
         if (wr_start) begin
            block_start_addr_nxt = i_reg_wdata;
         end
         if (wr_end) begin
            block_end_addr_nxt = i_reg_wdata;
         end
      end
      if (wr_mode) begin
         proc_mode_status_nxt = i_reg_wdata;
      end else if (do_exit) begin
         proc_mode_status_nxt[BRS_ACTIVE_BIT] = 1'b0;
      end
      // Hardware set wins over a software clear in the same cycle
      if (i_repeat_block_instr_exec) begin
         proc_mode_status_nxt[BRS_ACTIVE_BIT] = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         block_loop_count_r <= BRS_RST_LOOP_COUNT;
         block_start_addr_r <= BRS_RST_START_ADDR;
         block_end_addr_r   <= BRS_RST_END_ADDR;
         proc_mode_status_r <= BRS_RST_MODE;
      end else begin
         block_loop_count_r <= block_loop_count_nxt;
         block_start_addr_r <= block_start_addr_nxt;
         block_end_addr_r   <= block_end_addr_nxt;
         proc_mode_status_r <= proc_mode_status_nxt;
      end
   end

   // Fetch redirect and interrupt hold-off
   always_comb begin
      redirect_nxt      = do_loop;
      redirect_addr_nxt = do_loop ? block_start_addr_r : redirect_addr_r;
      loop_exit_nxt     = do_exit;
      // Hold stays until the next fetch leaves the last two words
      int_defer_nxt     = i_pc_upd ? in_window : int_defer_r;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         redirect_r      <= 1'b0;
         redirect_addr_r <= BRS_RST_START_ADDR;
         loop_exit_r     <= 1'b0;
         int_defer_r     <= 1'b0;
      end else begin
         redirect_r      <= redirect_nxt;
         redirect_addr_r <= redirect_addr_nxt;
         loop_exit_r     <= loop_exit_nxt;
         int_defer_r     <= int_defer_nxt;
      end
   end

   // Register readback, one cycle after the strobe
   always_comb begin
      rdata_nxt = BRS_RD_IDLE;
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            BRS_OFF_LOOP_COUNT: rdata_nxt = block_loop_count_r;
            BRS_OFF_START_ADDR: rdata_nxt = block_start_addr_r;
            BRS_OFF_END_ADDR:   rdata_nxt = block_end_addr_r;
            BRS_OFF_MODE:       rdata_nxt = proc_mode_status_r;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         rdata_r <= BRS_RD_IDLE;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // No port for branches, calls or single repeats: they cannot touch loop state
   assign o_reg_rdata           = rdata_r;
   assign o_redirect            = redirect_r;
   assign o_redirect_addr       = redirect_addr_r;
   assign o_loop_exit           = loop_exit_r;
   assign o_int_defer           = int_defer_r;
   assign o_block_repeat_active = proc_mode_status_r[BRS_ACTIVE_BIT];

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   count_load_a: assert property (
      wr_count |=> block_loop_count_r == $past(i_reg_wdata))
      else $error("loop count not loaded by write");

   repeat_block_instr_load_a: assert property (
      i_repeat_block_instr_exec |=> (block_start_addr_r == $past(i_repeat_block_instr_next_addr))
                      && (block_end_addr_r == $past(i_repeat_block_instr_end_addr)))
      else $error("start or end address not loaded by repeat-block");

   repeat_block_instr_sets_a: assert property (
      i_repeat_block_instr_exec |=> o_block_repeat_active)
      else $error("active flag not set by repeat-block");

   loop_back_a: assert property (
      (i_pc_upd && active && i_pc == block_end_addr_r
       && block_loop_count_r != 16'h0000 && !wr_count)
      |=> o_redirect && o_redirect_addr == $past(block_start_addr_r)
          && block_loop_count_r == brs_word_t'($past(block_loop_count_r) - 16'h0001))
      else $error("loop-back missing or count not decremented");

   loop_exit_a: assert property (
      (i_pc_upd && active && i_pc == block_end_addr_r
       && block_loop_count_r == 16'h0000 && !wr_mode && !i_repeat_block_instr_exec)
      |=> !o_block_repeat_active && !o_redirect && o_loop_exit)
      else $error("loop did not end on zero count");

   mode_write_a: assert property (
      (wr_mode && !i_repeat_block_instr_exec)
      |=> o_block_repeat_active == $past(i_reg_wdata[BRS_ACTIVE_BIT]))
      else $error("active flag not written from mode bit 0");

   sw_exit_a: assert property (
      (wr_mode && !i_reg_wdata[BRS_ACTIVE_BIT] && !i_repeat_block_instr_exec)
      ##1 (!i_repeat_block_instr_exec && !i_reg_wr) [*8]
      |=> !o_redirect && !o_loop_exit)
      else $error("jumped back after software clear");

   readback_a: assert property (
      (i_reg_rd && i_reg_addr == BRS_OFF_LOOP_COUNT)
      |=> o_reg_rdata == $past(block_loop_count_r) ##1 o_reg_rdata == 16'h0000
          || $past(i_reg_rd))
      else $error("loop count readback wrong");

   window_defer_a: assert property (
      (i_pc_upd && active && (i_pc == block_end_addr_r
                              || i_pc == brs_word_t'(block_end_addr_r - 16'h0001)))
      |=> o_int_defer)
      else $error("interrupt not held in last two words");

   defer_release_a: assert property (
      (o_redirect && i_pc_upd && i_pc == o_redirect_addr && i_pc != block_end_addr_r
       && i_pc != brs_word_t'(block_end_addr_r - 16'h0001))
      |=> !o_int_defer)
      else $error("held interrupt not released at block start");

   idle_ignore_a: assert property (
      (i_pc_upd && !active && !i_reg_wr)
      |=> !o_redirect && !o_loop_exit && $stable(block_loop_count_r))
      else $error("match acted on while inactive");

   count_hold_a: assert property (
      (!wr_count && !(i_pc_upd && active && i_pc == block_end_addr_r))
      |=> $stable(block_loop_count_r))
      else $error("loop count changed without write or end match");

   addr_hold_a: assert property (
      (!i_repeat_block_instr_exec && !wr_start && !wr_end)
      |=> $stable(block_start_addr_r) && $stable(block_end_addr_r))
      else $error("start or end address changed on its own");

   exit_at_end_a: assert property (
      o_loop_exit |-> $past(i_pc_upd) && $past(i_pc) == $past(block_end_addr_r))
      else $error("loop exit away from the end address");

   redirect_at_end_a: assert property (
      o_redirect |-> $past(i_pc_upd) && $past(active)
                     && $past(i_pc) == $past(block_end_addr_r))
      else $error("loop-back away from the end word");

   defer_hold_a: assert property (
      !i_pc_upd |=> $stable(o_int_defer))
      else $error("interrupt hold changed without a fetch");

   outside_window_a: assert property (
      (i_pc_upd && !(active && (i_pc == block_end_addr_r
                                || i_pc == brs_word_t'(block_end_addr_r - 16'h0001))))
      |=> !o_int_defer)
      else $error("interrupt held outside the end window");

   rd_idle_a: assert property (
      !i_reg_rd |=> o_reg_rdata == 16'h0000)
      else $error("read data outside the answer cycle");

   mode_store_a: assert property (
      wr_mode |=> proc_mode_status_r[15:1] == $past(i_reg_wdata[15:1]))
      else $error("mode status upper bits not stored");

   reset_clear_a: assert property (@(posedge i_sys_clk) disable iff (1'b0)
      i_sys_rst |=> !o_block_repeat_active && !o_redirect && !o_int_defer)
      else $error("active flag survives reset");

   loop_back_c: cover property (o_redirect ##[1:20] o_redirect);
   loop_exit_c: cover property (o_redirect ##[1:40] o_loop_exit);
   sw_clear_c:  cover property (wr_mode && !i_reg_wdata[BRS_ACTIVE_BIT] && active);
   defer_c:     cover property (o_int_defer ##1 o_redirect);

endmodule

// ---- tb/brs_fetch_model.sv ----
`timescale 1ns/1ps
module brs_fetch_model
   import brs_pkg::*;
(
   input  wire logic      i_clk,
   input  wire logic      i_rst,
   input  wire logic      i_go,
   input  wire brs_word_t i_first,
   input  wire brs_word_t i_stop,
   input  wire logic      i_redirect,
   input  wire brs_word_t i_redirect_addr,
   output logic           o_pc_upd,
   output brs_word_t      o_pc,
   output logic           o_busy
);
   logic      run_r;
   brs_word_t seq_r;

   // Loop start replaces the word after the end; idle bus never shows the last address
   always_comb begin
      o_pc_upd = run_r;
      o_busy   = run_r;
      if (!run_r) begin
         o_pc = ~seq_r;
      end else if (i_redirect) begin
         o_pc = i_redirect_addr;
      end else begin
         o_pc = seq_r;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         run_r <= 1'b0;
         seq_r <= 16'h0000;
      end else if (i_go) begin
         run_r <= 1'b1;
         seq_r <= i_first;
      end else if (run_r) begin
         seq_r <= o_pc + 16'h0001;
         if (o_pc == i_stop) begin
            run_r <= 1'b0;
         end
      end
   end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
   import brs_pkg::*;
   logic        i_sys_clk, i_sys_rst, i_reg_wr, i_reg_rd, i_repeat_block_instr_exec, go, busy;
   logic        i_pc_upd, o_redirect, o_loop_exit, o_int_defer, o_block_repeat_active;
   brs_reg_t    i_reg_addr;
   brs_word_t   i_reg_wdata, i_repeat_block_instr_next_addr, i_repeat_block_instr_end_addr, i_pc, first, stop;
   logic [15:0] o_reg_rdata, o_redirect_addr;
   int          failures, tests_run, n_redir, n_exit, n_defer;

   brs_sequencer u_dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .o_reg_rdata(o_reg_rdata), .i_pc_upd(i_pc_upd), .i_pc(i_pc), .i_repeat_block_instr_exec(i_repeat_block_instr_exec),
      .i_repeat_block_instr_next_addr(i_repeat_block_instr_next_addr), .i_repeat_block_instr_end_addr(i_repeat_block_instr_end_addr),
      .o_redirect(o_redirect), .o_redirect_addr(o_redirect_addr), .o_loop_exit(o_loop_exit),
      .o_int_defer(o_int_defer), .o_block_repeat_active(o_block_repeat_active));

   brs_fetch_model u_cpu (.i_clk(i_sys_clk), .i_rst(i_sys_rst), .i_go(go), .i_first(first),
      .i_stop(stop), .i_redirect(o_redirect), .i_redirect_addr(o_redirect_addr),
      .o_pc_upd(i_pc_upd), .o_pc(i_pc), .o_busy(busy));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("failures=%0d tests_run=%0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic wr(input brs_reg_t a, input brs_word_t d);
      @(posedge i_sys_clk);
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      i_reg_wr    <= 1'b1;
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input brs_reg_t a, input brs_word_t exp);
      @(posedge i_sys_clk);
      i_reg_addr <= a;
      i_reg_rd   <= 1'b1;
      @(posedge i_sys_clk);
      i_reg_rd <= 1'b0;
      #1;
      chk(o_reg_rdata, exp);
   endtask

   // Load the count, then issue the repeat-block instruction when repeat_single_instr is set, and start fetching
   task automatic start(input brs_word_t cnt, input brs_word_t b, input brs_word_t e,
                        input logic repeat_single_instr);
      wr(BRS_OFF_LOOP_COUNT, cnt);
      n_redir = 0;
      n_exit  = 0;
      n_defer = 0;
      first   = b;
      stop    = e + 16'h0001;
      @(posedge i_sys_clk);
      go               <= 1'b1;
      i_repeat_block_instr_exec      <= repeat_single_instr;
      i_repeat_block_instr_next_addr <= b;
      i_repeat_block_instr_end_addr  <= e;
      @(posedge i_sys_clk);
      go          <= 1'b0;
      i_repeat_block_instr_exec <= 1'b0;
      #1;
   endtask

   task automatic wait_on(input logic want_redirect);
      int n;
      n = 0;
      while ((want_redirect ? o_redirect !== 1'b1 : busy !== 1'b0) && n < 400) begin
         @(posedge i_sys_clk);
         #1;
         n++;
      end
      if (n >= 400) begin
         failures++;
         results();
      end
   endtask

   always @(negedge i_sys_clk) begin
      if (o_redirect === 1'b1) begin
         n_redir++;
         chk(o_redirect_addr, first);
      end
      if (o_loop_exit === 1'b1) n_exit++;
      if (o_int_defer === 1'b1) n_defer++;
   end

   initial begin
      i_sys_clk = 1'b0;
      forever #10 i_sys_clk = ~i_sys_clk;
   end

   initial begin
      {i_sys_rst, i_reg_wr, i_reg_rd, i_repeat_block_instr_exec, go} = 5'h10;
      {i_reg_addr, i_reg_wdata, i_repeat_block_instr_next_addr, i_repeat_block_instr_end_addr, first, stop} = '0;
      {failures, tests_run, n_redir, n_exit, n_defer} = '0;
      repeat (8) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      rd(BRS_OFF_LOOP_COUNT, BRS_RST_LOOP_COUNT);
      rd(BRS_OFF_START_ADDR, BRS_RST_START_ADDR);
      rd(BRS_OFF_END_ADDR, BRS_RST_END_ADDR);
      rd(BRS_OFF_MODE, BRS_RST_MODE);
      wr(BRS_OFF_LOOP_COUNT, 16'hFFFF);
      rd(BRS_OFF_LOOP_COUNT, 16'hFFFF);
      wr(BRS_OFF_START_ADDR, 16'h0A5C);
      rd(BRS_OFF_START_ADDR, 16'h0A5C);
      wr(BRS_OFF_END_ADDR, 16'h5A3C);
      rd(BRS_OFF_END_ADDR, 16'h5A3C);
      wr(BRS_OFF_MODE, 16'h0001);
      chk(o_block_repeat_active, 16'h0001);
      wr(BRS_OFF_MODE, 16'hFFFE);
      chk(o_block_repeat_active, 16'h0000);
      rd(BRS_OFF_MODE, 16'hFFFE);
      // Two repeats of a five-word block
      start(16'h0002, 16'h0100, 16'h0104, 1'b1);
      wait_on(1'b0);
      chk(n_redir, 2);
      chk(n_exit, 1);
      chk(n_defer, 6);
      chk(o_block_repeat_active, 16'h0000);
      rd(BRS_OFF_LOOP_COUNT, 16'h0000);
      rd(BRS_OFF_START_ADDR, 16'h0100);
      rd(BRS_OFF_END_ADDR, 16'h0104);
      // Zero count: one pass only
      start(16'h0000, 16'h0300, 16'h0302, 1'b1);
      wait_on(1'b0);
      chk(n_redir, 0);
      chk(n_exit, 1);
      chk(n_defer, 2);
      // Software clear early in the second pass
      start(16'h0005, 16'h0200, 16'h0209, 1'b1);
      wait_on(1'b1);
      chk(o_block_repeat_active, 16'h0001);
      wr(BRS_OFF_MODE, 16'h0000);
      wait_on(1'b0);
      chk(n_redir, 1);
      chk(n_exit, 0);
      chk(n_defer, 2);
      rd(BRS_OFF_LOOP_COUNT, 16'h0004);
      // Fetch across the end address with the flag clear
      start(16'h0003, 16'h0200, 16'h020A, 1'b0);
      wait_on(1'b0);
      chk(n_redir, 0);
      chk(n_exit, 0);
      chk(n_defer, 0);
      rd(BRS_OFF_LOOP_COUNT, 16'h0003);
      results();
   end
endmodule
